//--- verilog/nvmcb_top.sv
// command register, trigger decode and busy sequencing of the memory
`timescale 1ns/10ps
`default_nettype none
module nvmcb_top #(
  parameter int WIPE_CYCLES = nvmcb_pkg::WIPE_CYCLES,
  parameter int PROGRAM_CYCLES = nvmcb_pkg::PROGRAM_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic [15:0] memAddr,
  input wire logic memWrEn,
  input wire logic memRdEn,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData,
  output logic memRdRefused,
  output logic arrRdEn,
  output logic [15:0] arrRdAddr,
  input wire logic [7:0] arrRdData,
  output logic opStart,
  output nvmcb_pkg::nvmcb_op_s opInfo,
  output logic memoryBusyFlag
);

  localparam logic [nvmcb_pkg::COUNT_WIDTH-1:0] WIPE_LOAD =
    nvmcb_pkg::COUNT_WIDTH'(WIPE_CYCLES);
  localparam logic [nvmcb_pkg::COUNT_WIDTH-1:0] PROGRAM_LOAD =
    nvmcb_pkg::COUNT_WIDTH'(PROGRAM_CYCLES);
  localparam logic [nvmcb_pkg::COUNT_WIDTH-1:0] COUNT_ONE =
    nvmcb_pkg::COUNT_WIDTH'(1);

  // true when addr lies in the inclusive window base..last
  function automatic logic inWindow(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input logic [15:0] last);
    inWindow = (addr >= base) && (addr <= last);
  endfunction

  // section that a data-space address falls into
  function automatic nvmcb_pkg::nvmcb_target_e targetOf(
      input logic [15:0] addr);
    if (inWindow(addr, nvmcb_pkg::CODE_BASE, nvmcb_pkg::CODE_LAST)) begin
      targetOf = nvmcb_pkg::NVMCB_TGT_CODE;
    end else if (inWindow(addr, nvmcb_pkg::CONFIG_BASE,
                          nvmcb_pkg::CONFIG_LAST)) begin
      targetOf = nvmcb_pkg::NVMCB_TGT_CONFIG;
    end else if (inWindow(addr, nvmcb_pkg::LOCK_BASE,
                          nvmcb_pkg::LOCK_LAST)) begin
      targetOf = nvmcb_pkg::NVMCB_TGT_LOCK;
    end else begin
      targetOf = nvmcb_pkg::NVMCB_TGT_NONE;
    end
  endfunction

  nvmcb_pkg::nvmcb_state_e state_r;
  logic [nvmcb_pkg::COUNT_WIDTH-1:0] count_r;
  logic [nvmcb_pkg::CMD_MSB:0] cmd_r;
  logic lowValid_r;
  logic [14:0] lowWord_r;
  logic [7:0] lowData_r;
  logic [7:0] ioRdData_r;
  logic [7:0] memRdData_r;
  logic memRdRefused_r;
  logic opStart_r;
  nvmcb_pkg::nvmcb_op_s opInfo_r;

  logic busy;
  logic hiByte;
  nvmcb_pkg::nvmcb_target_e wrTarget;
  logic launch;
  nvmcb_pkg::nvmcb_op_s launchOp;
  logic [nvmcb_pkg::COUNT_WIDTH-1:0] launchCount;
  logic lowLoad;

  // busy covers every section, code and lock bits alike
  assign busy = (state_r == nvmcb_pkg::NVMCB_BUSY);
  assign hiByte = memAddr[0];
  assign wrTarget = targetOf(memAddr);

  // trigger decode: only the high-byte write of a word can start work
  always_comb begin
    launch = 1'b0;
    launchOp.op = nvmcb_pkg::NVMCB_OP_CHIP_WIPE;
    launchOp.target = wrTarget;
    launchOp.wordAddr = memAddr[15:1];
    launchOp.wordData = {memWrData, lowData_r};
    launchCount = WIPE_LOAD;
    if (memWrEn && !busy && hiByte &&
        wrTarget != nvmcb_pkg::NVMCB_TGT_NONE) begin
      case (cmd_r)
        nvmcb_pkg::CMD_CHIP_WIPE: begin
          // whole code array, lock bits go with it
          if (wrTarget == nvmcb_pkg::NVMCB_TGT_CODE) begin
            launch = 1'b1;
          end
        end
        nvmcb_pkg::CMD_SECTION_WIPE: begin
          if (wrTarget == nvmcb_pkg::NVMCB_TGT_CODE ||
              wrTarget == nvmcb_pkg::NVMCB_TGT_CONFIG) begin
            launch = 1'b1;
            launchOp.op = nvmcb_pkg::NVMCB_OP_SECTION_WIPE;
          end
        end
        nvmcb_pkg::CMD_WORD_PROGRAM: begin
          // needs the low byte of the very same word first
          if (lowValid_r && lowWord_r == memAddr[15:1]) begin
            launch = 1'b1;
            launchOp.op = nvmcb_pkg::NVMCB_OP_WORD_PROGRAM;
            launchCount = PROGRAM_LOAD;
          end
        end
        default: begin
          launch = 1'b0;
        end
      endcase
    end
  end

  // a low-byte write under the program command fills the buffer
  assign lowLoad = memWrEn && !busy && !hiByte &&
                   wrTarget != nvmcb_pkg::NVMCB_TGT_NONE &&
                   cmd_r == nvmcb_pkg::CMD_WORD_PROGRAM;

  // sequencer: busy from the launch edge until the count runs out
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= nvmcb_pkg::NVMCB_IDLE;
      count_r <= '0;
    end else begin
      case (state_r)
        nvmcb_pkg::NVMCB_IDLE: begin
          if (launch) begin
            state_r <= nvmcb_pkg::NVMCB_BUSY;
            count_r <= launchCount;
          end
        end
        nvmcb_pkg::NVMCB_BUSY: begin
          // held without a gap; drops only when the count is spent
          if (count_r <= COUNT_ONE) begin
            state_r <= nvmcb_pkg::NVMCB_IDLE;
            count_r <= '0;
          end else begin
            count_r <= count_r - COUNT_ONE;
          end
        end
        default: begin
          state_r <= nvmcb_pkg::NVMCB_IDLE;
          count_r <= '0;
        end
      endcase
    end
  end

  // launch pulse and the operation details handed to the array
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opStart_r <= 1'b0;
      opInfo_r <= '0;
    end else begin
      opStart_r <= launch;
      if (launch) begin
        opInfo_r <= launchOp;
      end
    end
  end

  // low-byte buffer, emptied by any launch, wipe or program
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lowValid_r <= 1'b0;
      lowWord_r <= '0;
      lowData_r <= '0;
    end else if (lowLoad) begin
      lowValid_r <= 1'b1;
      lowWord_r <= memAddr[15:1];
      lowData_r <= memWrData;
    end else if (launch) begin
      lowValid_r <= 1'b0;
    end
  end

  // command register, any six-bit value may be stored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_r <= nvmcb_pkg::CMD_RESET;
    end else if (ioWrEn && ioAddr == nvmcb_pkg::CMD_OFFSET) begin
      cmd_r <= ioWrData[nvmcb_pkg::CMD_MSB:0];
    end
  end

  // i/o read port, answered on the edge after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ioRdData_r <= nvmcb_pkg::READ_ZERO;
    end else if (ioRdEn) begin
      if (ioAddr == nvmcb_pkg::STATUS_OFFSET) begin
        ioRdData_r <= nvmcb_pkg::READ_ZERO;
        ioRdData_r[nvmcb_pkg::BUSY_BIT] <= busy;
      end else if (ioAddr == nvmcb_pkg::CMD_OFFSET) begin
        ioRdData_r <= {2'h0, cmd_r};
      end else begin
        ioRdData_r <= nvmcb_pkg::READ_ZERO;
      end
    end
  end

  // array reads pass only while idle
  assign arrRdEn = memRdEn && !busy;
  assign arrRdAddr = memAddr;

  // memory read data, zero and a refusal pulse when busy
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      memRdData_r <= nvmcb_pkg::READ_ZERO;
      memRdRefused_r <= 1'b0;
    end else begin
      memRdRefused_r <= memRdEn && busy;
      if (memRdEn) begin
        memRdData_r <= busy ? nvmcb_pkg::READ_ZERO : arrRdData;
      end
    end
  end

  assign ioRdData = ioRdData_r;
  assign memRdData = memRdData_r;
  assign memRdRefused = memRdRefused_r;
  assign opStart = opStart_r;
  assign opInfo = opInfo_r;
  assign memoryBusyFlag = busy;

endmodule
`default_nettype wire

//--- verilog/nvmcb_pkg.sv
// constants, types and layouts of the memory command and busy block
// Behaviour
// - busy flag sits in status bit 7
// - busy rises at start, holds until done
// - code array and lock bits both raise busy
// - six-bit read/write command field, bits 5:0
// - command register at 0x33, resets to no-op
// - decode 0x10, 0x14, 0x1D as wipe/wipe/program
// - wipe starts on high-byte dummy write
// - low byte buffered, high byte starts program
// - busy blocks other programming and all data-space reads
`default_nettype none
package nvmcb_pkg;

  // register offsets in the i/o space
  localparam logic [5:0] STATUS_OFFSET = 6'h32;
  localparam logic [5:0] CMD_OFFSET = 6'h33;

  // field positions and reset values
  localparam int BUSY_BIT = 7;
  localparam int CMD_MSB = 5;
  localparam int CMD_WIDTH = 6;
  localparam logic [5:0] CMD_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // command codes held in memory_command_select
  localparam logic [5:0] CMD_NOP = 6'h00;
  localparam logic [5:0] CMD_CHIP_WIPE = 6'h10;
  localparam logic [5:0] CMD_SECTION_WIPE = 6'h14;
  localparam logic [5:0] CMD_WORD_PROGRAM = 6'h1D;

  // data-space windows onto the non-volatile sections
  localparam logic [15:0] LOCK_BASE = 16'h3F00;
  localparam logic [15:0] LOCK_LAST = 16'h3F01;
  localparam logic [15:0] CONFIG_BASE = 16'h3F40;
  localparam logic [15:0] CONFIG_LAST = 16'h3F41;
  localparam logic [15:0] CODE_BASE = 16'h4000;
  localparam logic [15:0] CODE_LAST = 16'h43FF;

  // default duration of each operation, in ref_clk cycles
  localparam int WIPE_CYCLES = 64;
  localparam int PROGRAM_CYCLES = 32;
  localparam int COUNT_WIDTH = 16;

  // operation kinds passed to the array
  typedef enum logic [1:0] {
    NVMCB_OP_CHIP_WIPE,
    NVMCB_OP_SECTION_WIPE,
    NVMCB_OP_WORD_PROGRAM
  } nvmcb_op_e;

  // section addressed by a data-space access
  typedef enum logic [1:0] {
    NVMCB_TGT_NONE,
    NVMCB_TGT_CODE,
    NVMCB_TGT_CONFIG,
    NVMCB_TGT_LOCK
  } nvmcb_target_e;

  // everything the array needs to run one operation
  typedef struct packed {
    nvmcb_op_e op;
    nvmcb_target_e target;
    logic [14:0] wordAddr;
    logic [15:0] wordData;
  } nvmcb_op_s;

  // sequencer states
  typedef enum logic [0:0] {
    NVMCB_IDLE,
    NVMCB_BUSY
  } nvmcb_state_e;

endpackage
`default_nettype wire

//--- testbench/nvmcb_checker.sv
// port assertions for the memory command and busy block
`timescale 1ns/10ps
`default_nettype none
module nvmcb_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [5:0] ioAddr,
  input wire logic ioRdEn,
  input wire logic [7:0] ioRdData,
  input wire logic memWrEn,
  input wire logic memRdEn,
  input wire logic [7:0] memRdData,
  input wire logic memRdRefused,
  input wire logic arrRdEn,
  input wire logic [7:0] arrRdData,
  input wire logic opStart,
  input wire logic memoryBusyFlag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // busy timing against launches
  AST_BUSY_START: assert property ($rose(memoryBusyFlag) |-> opStart)
    else $error("busy rose without launch");
  AST_BUSY_HOLD: assert property (opStart |-> memoryBusyFlag[*4])
    else $error("busy dropped early");
  AST_ONE_PULSE: assert property (opStart |=> !opStart)
    else $error("launch pulse too long");
  // blocking while busy
  AST_NO_ARR_RD: assert property (memoryBusyFlag |-> !arrRdEn)
    else $error("array read while busy");
  AST_RD_REFUSE: assert property (memRdEn && memoryBusyFlag |=>
    memRdRefused && memRdData == 8'h00)
    else $error("busy read not refused");
  AST_RD_PASS: assert property (memRdEn && !memoryBusyFlag |=>
    !memRdRefused && memRdData == $past(arrRdData))
    else $error("idle read wrong");
  AST_NO_LAUNCH: assert property (memWrEn && memoryBusyFlag |=> !opStart)
    else $error("launch while busy");
  // register read layout
  AST_STATUS: assert property (ioRdEn && ioAddr == 6'h32 |=>
    ioRdData == {$past(memoryBusyFlag), 7'h00})
    else $error("status read wrong");
endmodule
bind nvmcb_top nvmcb_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .ioAddr(ioAddr), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
  .memWrEn(memWrEn), .memRdEn(memRdEn), .memRdData(memRdData),
  .memRdRefused(memRdRefused), .arrRdEn(arrRdEn), .arrRdData(arrRdData),
  .opStart(opStart), .memoryBusyFlag(memoryBusyFlag));
`default_nettype wire

//--- testbench/nvmcb_array_model.sv
// behavioural read port of the memory array
`timescale 1ns/10ps
`default_nettype none
module nvmcb_array_model (
  input wire logic ref_clk,
  input wire logic arrRdEn,
  input wire logic [15:0] arrRdAddr,
  output logic [7:0] arrRdData
);
  logic [7:0] noise = 8'h00;
  // idle pattern moves every cycle so stale data never matches
  always @(posedge ref_clk) noise <= noise + 8'h3B;
  // address-derived data while a read is requested
  assign arrRdData = arrRdEn ? arrRdAddr[7:0] ^ 8'h5A : noise;
endmodule
`default_nettype wire

//--- testbench/nvmcb_top_tb.sv
// self-checking bench for the memory command and busy block
`timescale 1ns/10ps
`default_nettype none
module nvmcb_top_tb;
  localparam int WL = 6;
  localparam int PL = 10;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] ioAddr = 6'h00;
  logic ioWrEn = 1'b0;
  logic ioRdEn = 1'b0;
  logic [7:0] ioWrData = 8'h00;
  logic [15:0] memAddr = 16'h0000;
  logic memWrEn = 1'b0;
  logic memRdEn = 1'b0;
  logic [7:0] memWrData = 8'h00;
  logic [7:0] ioRdData, memRdData, arrRdData;
  logic memRdRefused, arrRdEn, opStart, memoryBusyFlag;
  logic [15:0] arrRdAddr;
  nvmcb_pkg::nvmcb_op_s opInfo;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  nvmcb_top #(.WIPE_CYCLES(WL), .PROGRAM_CYCLES(PL)) DUT (.ref_clk(ref_clk),
    .rstn(rstn), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .memAddr(memAddr),
    .memWrEn(memWrEn), .memRdEn(memRdEn), .memWrData(memWrData),
    .memRdData(memRdData), .memRdRefused(memRdRefused), .arrRdEn(arrRdEn),
    .arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .opStart(opStart),
    .opInfo(opInfo), .memoryBusyFlag(memoryBusyFlag));
  nvmcb_array_model u_arr (.ref_clk(ref_clk), .arrRdEn(arrRdEn),
    .arrRdAddr(arrRdAddr), .arrRdData(arrRdData));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // one register access, strobe held for one edge
  task automatic io(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = wr;
    ioRdEn = !wr;
    @(negedge ref_clk);
    ioWrEn = 1'b0;
    ioRdEn = 1'b0;
  endtask
  // one data-space byte access
  task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    memAddr = a;
    memWrData = d;
    memWrEn = wr;
    memRdEn = !wr;
    @(negedge ref_clk);
    memWrEn = 1'b0;
    memRdEn = 1'b0;
  endtask
  // trigger write, then measure the busy period
  task automatic launch(input logic [15:0] a, input logic [7:0] d,
    input logic [1:0] op, input int len);
    int cnt;
    cnt = 0;
    mem(1'b1, a, d);
    chk(opStart, 1'b1);
    chk(opInfo.op, op);
    while (memoryBusyFlag === 1'b1 && cnt < 50) begin
      cnt++;
      @(negedge ref_clk);
    end
    chk(cnt, len);
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    io(1'b0, 6'h33, 8'h00);
    chk(ioRdData, 8'h00);
    io(1'b0, 6'h32, 8'h00);
    chk(ioRdData, 8'h00);
    mem(1'b1, 16'h4001, 8'h00);
    chk(opStart, 1'b0);
    io(1'b1, 6'h33, 8'hFF);
    io(1'b0, 6'h33, 8'h00);
    chk(ioRdData, 8'h3F);
    mem(1'b1, 16'h4001, 8'h00);
    chk(opStart, 1'b0);
    $display("test reset and command done");
    io(1'b1, 6'h33, 8'h10);
    launch(16'h4101, 8'hA5, nvmcb_pkg::NVMCB_OP_CHIP_WIPE, WL);
    io(1'b1, 6'h33, 8'h14);
    launch(16'h3F41, 8'hA5, nvmcb_pkg::NVMCB_OP_SECTION_WIPE, WL);
    io(1'b1, 6'h33, 8'h1D);
    mem(1'b1, 16'h3F00, 8'h5C);
    launch(16'h3F01, 8'hA5, nvmcb_pkg::NVMCB_OP_WORD_PROGRAM, PL);
    chk(opInfo.target, nvmcb_pkg::NVMCB_TGT_LOCK);
    mem(1'b1, 16'h4000, 8'h34);
    mem(1'b1, 16'h4003, 8'h77);
    chk(opStart, 1'b0);
    launch(16'h4001, 8'h12, nvmcb_pkg::NVMCB_OP_WORD_PROGRAM, PL);
    chk(opInfo.wordData, 16'h1234);
    chk(opInfo.wordAddr, 15'h2000);
    $display("test operations done");
    mem(1'b1, 16'h4000, 8'h01);
    mem(1'b1, 16'h4001, 8'h02);
    io(1'b0, 6'h32, 8'h00);
    chk(ioRdData, 8'h80);
    mem(1'b0, 16'h4002, 8'h00);
    chk(memRdRefused, 1'b1);
    chk(memRdData, 8'h00);
    // a wipe armed mid-operation must still be held off by busy
    io(1'b1, 6'h33, 8'h10);
    mem(1'b1, 16'h4001, 8'h03);
    chk(opStart, 1'b0);
    repeat (PL) @(negedge ref_clk);
    mem(1'b0, 16'h4002, 8'h00);
    chk(memRdData, 8'h58);
    $display("test blocking done");
    print_verdict();
  end
endmodule
`default_nettype wire
